// file: rtl/table_insertion_engine.sv
// table insertion engine with its stream fifo

// byte fifo with registered full and empty flags
module stream_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  output logic [WIDTH-1:0]      rd_data,
  output logic                  rd_valid,
  input  wire logic             rd_ready
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign push    = wr_valid && wr_ready;
  assign pop     = rd_valid && rd_ready;
  assign rd_data = mem[rptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  // storage has no reset; only the pointers matter
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wptr] <= wr_data;
    end
  end

  // pointers wrap at depth, which need not be a power of two
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (push) begin
        wptr <= (wptr == LAST_PTR) ? '0 : wptr + 1'b1;
      end
      if (pop) begin
        rptr <= (rptr == LAST_PTR) ? '0 : rptr + 1'b1;
      end
    end
  end

  // flags registered so the block's ready pin comes from a flop
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      count    <= '0;
      wr_ready <= 1'b0;
      rd_valid <= 1'b0;
    end else begin
      count    <= next_count;
      wr_ready <= (next_count != FULL_CNT);
      rd_valid <= (next_count != '0);
    end
  end
endmodule : stream_fifo

module table_insertion_engine
  import table_insert_pkg::*;
#(
  parameter int unsigned ADDR_W     = 16,
  parameter int unsigned MS_CNT     = MS_CYCLES,
  parameter int unsigned CC_ENTRIES = 8
) (
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  input  wire logic [7:0]        in_data,
  input  wire logic              in_sop,
  input  wire logic              in_valid,
  output logic                   in_ready,
  output logic [7:0]             out_data,
  output logic                   out_sop,
  output logic                   out_valid,
  input  wire logic              out_ready,
  output logic [ADDR_W-1:0]      flash_addr,
  output logic                   flash_rd,
  input  wire logic [7:0]        flash_rdata,
  input  wire logic              flash_rvalid,
  output logic                   overflow_led
);
  localparam int unsigned CW = (CC_ENTRIES > 1) ? $clog2(CC_ENTRIES) : 1;
  localparam logic [7:0] LAST_POS = 8'(PKT_LEN - 1);
  localparam logic [7:0] POS_PID  = 8'(IDX_PID_LO);

  // stream path signals
  logic [FIFO_WIDTH-1:0] fifo_data;
  logic                  fifo_valid;
  logic                  adv;
  logic [7:0]            d_byte [3];
  logic [2:0]            d_sop;
  logic [2:0]            d_v;
  logic [7:0]            in_pos;
  logic                  subst;
  logic [7:0]            sub_pos;
  logic                  sub_done;
  logic [7:0]            sub_byte;
  logic                  null_hit;

  // engine signals
  engine_state_e         state;
  logic [7:0]            pkt_buf [PKT_LEN];
  logic [ADDR_W-1:0]     slot_base;
  logic [7:0]            rd_off;
  logic                  rd_busy;
  logic [1:0]            hdr_idx;
  logic [7:0]            copies;
  logic [7:0]            timing;
  logic [7:0]            cls;
  logic [8:0]            wait_ms;
  logic [8:0]            ms_done;
  logic [8:0]            cycle_ms;
  logic [4:0]            cycle_no;
  logic                  armed;
  logic [12:0]           cur_pid;
  logic [3:0]            send_cc;
  logic                  user_pkt;
  logic                  eligible;

  // timers and cc table
  logic [$clog2(MS_CNT+1)-1:0] ms_cnt;
  logic                  ms_tick;
  logic [9:0]            led_ms;
  logic [12:0]           tag_pid [CC_ENTRIES];
  logic [3:0]            tag_cc  [CC_ENTRIES];
  logic [CC_ENTRIES-1:0] tag_v;
  logic                  cc_hit;
  logic [CW-1:0]         cc_idx;
  logic [CW-1:0]         alloc_ptr;

  // eight-word buffer; its ready is the block's ready to the source
  stream_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .wr_data  ({in_sop, in_data}),
    .wr_valid (in_valid),
    .wr_ready (in_ready),
    .rd_data  (fifo_data),
    .rd_valid (fifo_valid),
    .rd_ready (adv)
  );

  // the stream only moves when the multiplexer can take a byte
  assign adv = fifo_valid && (out_ready || !out_valid);
  assign null_hit = (in_pos == POS_PID - 8'h01) &&
                    ({d_byte[0][4:0], fifo_data[7:0]} == NULL_PID);

  // inserted bytes: fresh sync, cc patched unless user packet
  always_comb begin
    sub_byte = pkt_buf[sub_pos];
    if (sub_pos == 8'h00) begin
      sub_byte = SYNC_BYTE;
    end else if (sub_pos == 8'(IDX_CC) && !user_pkt) begin
      sub_byte = {pkt_buf[IDX_CC][7:4], send_cc};
    end
  end

  // three-byte delay so the pid is known before byte zero leaves
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      d_byte    <= '{default: 8'h00};
      d_sop     <= 3'b000;
      d_v       <= 3'b000;
      in_pos    <= 8'h00;
      out_data  <= 8'h00;
      out_sop   <= 1'b0;
      out_valid <= 1'b0;
    end else if (adv) begin
      d_byte[0] <= fifo_data[7:0];
      d_byte[1] <= d_byte[0];
      d_byte[2] <= d_byte[1];
      d_sop     <= {d_sop[1:0], fifo_data[8]};
      d_v       <= {d_v[1:0], 1'b1};
      in_pos    <= fifo_data[8] ? 8'h00 : in_pos + 8'h01;
      out_data  <= subst ? sub_byte : d_byte[2];
      out_sop   <= d_sop[2];
      out_valid <= d_v[2];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

  // claim a null packet only while a stored packet is armed
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      subst    <= 1'b0;
      sub_pos  <= 8'h00;
      sub_done <= 1'b0;
    end else begin
      sub_done <= 1'b0;
      if (adv) begin
        if (subst) begin
          sub_pos <= sub_pos + 8'h01;
          if (sub_pos == LAST_POS) begin
            subst    <= 1'b0;
            sub_done <= 1'b1;
          end
        end else if (null_hit && fifo_data[8] == 1'b0 && armed &&
                     !sub_done) begin
          subst   <= 1'b1;
          sub_pos <= 8'h00;
        end
      end
    end
  end

  // free-running millisecond tick from the stream clock
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ms_cnt  <= '0;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= (ms_cnt == ($bits(ms_cnt))'(MS_CNT - 1));
      ms_cnt  <= (ms_cnt == ($bits(ms_cnt))'(MS_CNT - 1)) ? '0
                                                         : ms_cnt + 1'b1;
    end
  end

  // a byte refused at the input restarts the one second lamp
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      led_ms       <= 10'h000;
      overflow_led <= 1'b0;
    end else begin
      if (in_valid && !in_ready) begin
        led_ms <= 10'(LED_MS);
      end else if (ms_tick && led_ms != 10'h000) begin
        led_ms <= led_ms - 10'h001;
      end
      overflow_led <= (led_ms != 10'h000);
    end
  end

  // cc lookup by pid; first match wins
  always_comb begin
    cc_hit = 1'b0;
    cc_idx = '0;
    for (int i = CC_ENTRIES - 1; i >= 0; i--) begin
      if (tag_v[i] && tag_pid[i] == cur_pid) begin
        cc_hit = 1'b1;
        cc_idx = CW'(i);
      end
    end
  end

  // running cc advances once per sent non-user packet of that pid
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tag_v     <= '0;
      tag_pid   <= '{default: 13'h0000};
      tag_cc    <= '{default: 4'h0};
      alloc_ptr <= '0;
    end else if (sub_done && !user_pkt) begin
      if (cc_hit) begin
        tag_cc[cc_idx] <= tag_cc[cc_idx] + 4'h1;
      end else begin
        tag_v[alloc_ptr]   <= 1'b1;
        tag_pid[alloc_ptr] <= cur_pid;
        tag_cc[alloc_ptr]  <= 4'h1;
        alloc_ptr          <= alloc_ptr + 1'b1;
      end
    end
  end

  // class gating: sdt every 8th, nit and user every 32nd cycle
  always_comb begin
    eligible = (copies != 8'h00);
    if (cls[CLASS_USER_BIT]) begin
      eligible = eligible && (cycle_no == 5'(0));
    end else if (cur_pid == PID_NIT) begin
      eligible = eligible && (cycle_no == 5'(0));
    end else if (cur_pid == PID_SDT) begin
      eligible = eligible &&
                 (cycle_no[2:0] == 3'(SDT_EVERY % SDT_EVERY));
    end
  end

  // flash reads: one outstanding; address latched with the pulse so it
  // stays put until the answer even if the slot base moves meanwhile
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      flash_rd   <= 1'b0;
      flash_addr <= '0;
      rd_busy    <= 1'b0;
    end else begin
      flash_rd <= 1'b0;
      if (flash_rvalid) begin
        rd_busy <= 1'b0;
      end else if (!rd_busy && (state == S_PROBE || state == S_HDR ||
                                state == S_LOAD ||
                                (state == S_WAIT &&
                                 rd_off == 8'(IDX_CLASS)))) begin
        flash_rd   <= 1'b1;
        flash_addr <= slot_base + ADDR_W'(rd_off);
        rd_busy    <= 1'b1;
      end
    end
  end

  // sequencing through the stored slots
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= S_PROBE;
      slot_base <= '0;
      rd_off    <= 8'h00;
      hdr_idx   <= 2'd0;
      copies    <= 8'h00;
      timing    <= 8'h00;
      cls       <= 8'h00;
      wait_ms   <= 9'h000;
      ms_done   <= 9'h000;
      cycle_ms  <= 9'h000;
      cycle_no  <= 5'h00;
      armed     <= 1'b0;
      cur_pid   <= 13'h0000;
      send_cc   <= 4'h0;
      user_pkt  <= 1'b0;
    end else begin
      if (ms_tick && cycle_ms != 9'h1ff) begin
        cycle_ms <= cycle_ms + 9'h001;
      end
      unique case (state)
        S_PROBE: begin
          // an erased first slot lacks the sync byte
          if (flash_rvalid) begin
            if (flash_rdata == SYNC_BYTE) begin
              state   <= S_HDR;
              rd_off  <= 8'(IDX_PID_HI);
              hdr_idx <= 2'd0;
            end else begin
              state <= S_OFF;
            end
          end
        end
        S_HDR: begin
          if (flash_rvalid) begin
            hdr_idx <= hdr_idx + 2'd1;
            unique case (hdr_idx)
              2'd0: begin
                cur_pid[12:8] <= flash_rdata[4:0];
                rd_off        <= 8'(IDX_PID_LO);
              end
              2'd1: begin
                cur_pid[7:0] <= flash_rdata;
                rd_off       <= 8'(IDX_COUNT);
              end
              2'd2: begin
                copies <= flash_rdata;
                rd_off <= 8'(IDX_TIMING);
              end
              2'd3: begin
                timing  <= flash_rdata;
                rd_off  <= 8'(IDX_CLASS);
                hdr_idx <= 2'd3;
                state   <= S_WAIT;
                ms_done <= 9'h000;
                wait_ms <= 9'(flash_rdata) * 9'(WAIT_STEP_MS);
              end
            endcase
          end
        end
        S_WAIT: begin
          // class byte is fetched while the wait runs; offset parks at 0
          if (flash_rvalid) begin
            cls    <= flash_rdata;
            rd_off <= 8'h00;
          end
          if (timing == TIMING_WRAP) begin
            slot_base <= '0;
            state     <= S_PACE;
          end else if (ms_done >= wait_ms && !rd_busy && !flash_rd &&
                       rd_off != 8'(IDX_CLASS)) begin
            if (eligible) begin
              state    <= S_LOAD;
              rd_off   <= 8'h00;
              user_pkt <= cls[CLASS_USER_BIT];
            end else begin
              slot_base <= slot_base + ADDR_W'(SLOT_LEN);
              rd_off    <= 8'(IDX_PID_HI);
              hdr_idx   <= 2'd0;
              state     <= S_HDR;
            end
          end else if (ms_tick) begin
            ms_done <= ms_done + 9'h001;
          end
        end
        S_PACE: begin
          // a cycle never closes before the shortest pat period
          if (cycle_ms >= 9'(PAT_MIN_MS) && !rd_busy && !flash_rd) begin
            cycle_ms <= 9'h000;
            cycle_no <= 5'(cycle_no + 5'h01) & 5'(NIT_EVERY - 1);
            rd_off   <= 8'(IDX_PID_HI);
            hdr_idx  <= 2'd0;
            state    <= S_HDR;
          end
        end
        S_LOAD: begin
          if (flash_rvalid) begin
            pkt_buf[rd_off] <= flash_rdata;
            if (rd_off == LAST_POS) begin
              armed   <= 1'b1;
              send_cc <= cc_hit ? tag_cc[cc_idx] : 4'h0;
              state   <= S_SEND;
            end else begin
              rd_off <= rd_off + 8'h01;
            end
          end
        end
        S_SEND: begin
          // held here until enough null packets pass by
          if (sub_done) begin
            copies  <= copies - 8'h01;
            send_cc <= send_cc + 4'h1;
            if (copies == 8'h01) begin
              armed     <= 1'b0;
              slot_base <= slot_base + ADDR_W'(SLOT_LEN);
              rd_off    <= 8'(IDX_PID_HI);
              hdr_idx   <= 2'd0;
              state     <= S_HDR;
            end
          end
        end
        S_OFF: begin
          armed <= 1'b0;
        end
        default: begin
          state <= S_OFF;
        end
      endcase
    end
  end
endmodule : table_insertion_engine

// file: rtl/table_insert_pkg.sv
// constants shared by the table insertion engine and its stream path
package table_insert_pkg;

  // stream and stored packet geometry
  localparam int unsigned PKT_LEN    = 188;
  localparam int unsigned SLOT_LEN   = 204;
  localparam int unsigned IDX_COUNT  = 188;   // 189th byte: copies to send
  localparam int unsigned IDX_TIMING = 189;   // 190th byte: wait in 2 ms steps
  localparam int unsigned IDX_CLASS  = 190;   // 191st byte: packet class
  localparam int unsigned IDX_CC     = 3;     // header byte holding the cc
  localparam int unsigned IDX_PID_HI = 1;
  localparam int unsigned IDX_PID_LO = 2;
  localparam int unsigned CLASS_USER_BIT = 0;

  localparam logic [7:0]  TIMING_WRAP = 8'hff;
  localparam logic [7:0]  SYNC_BYTE   = 8'h47;
  localparam logic [12:0] NULL_PID    = 13'h1fff;
  localparam logic [12:0] PID_NIT     = 13'h0010;
  localparam logic [12:0] PID_SDT     = 13'h0011;

  // insertion cycle ratios
  localparam int unsigned SDT_EVERY = 8;
  localparam int unsigned NIT_EVERY = 32;

  // timing
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned MS_PER_S     = 1000;
  localparam int unsigned MS_CYCLES    = CLK_HZ / MS_PER_S;
  localparam int unsigned WAIT_STEP_MS = 2;
  localparam int unsigned PAT_MIN_MS   = 40;
  localparam int unsigned PAT_MAX_MS   = 508;
  localparam int unsigned LED_MS       = 1000;  // overflow lamp: one second

  // fifo in the stream path
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned FIFO_WIDTH = 9;       // sop flag and byte

  // engine states, gray along probe, header, wait, load, send
  typedef enum logic [2:0] {
    S_PROBE = 3'b000,
    S_HDR   = 3'b001,
    S_WAIT  = 3'b011,
    S_LOAD  = 3'b010,
    S_SEND  = 3'b110,
    S_PACE  = 3'b111,
    S_OFF   = 3'b101
  } engine_state_e;

endpackage : table_insert_pkg

// file: verif/engine_properties.sv
// concurrent checks on the table insertion engine ports
module engine_properties
  import table_insert_pkg::*;
#(
  parameter int unsigned ADDR_W = 16,
  parameter int unsigned MS_CNT = 10
) (
  input wire logic              sys_clk,
  input wire logic              arst_n,
  input wire logic              in_valid,
  input wire logic              in_ready,
  input wire logic [7:0]        out_data,
  input wire logic              out_sop,
  input wire logic              out_valid,
  input wire logic              out_ready,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic              flash_rd,
  input wire logic              flash_rvalid,
  input wire logic              overflow_led
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LIM = 1002 * MS_CNT + 4;
  localparam int LOW = 998 * MS_CNT;
  logic pend;
  int   led_cnt;
  int   ocnt;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // read outstanding, lamp age since last refusal, bytes since sop
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend    <= 1'b0;
      led_cnt <= 0;
      ocnt    <= 0;
    end else begin
      if (flash_rd) pend <= 1'b1;
      else if (flash_rvalid) pend <= 1'b0;
      led_cnt <= (!overflow_led || (in_valid && !in_ready)) ? 0 : led_cnt + 1;
      if (out_valid && out_ready)
        ocnt <= out_sop ? 1 : ((ocnt == 0) ? 0 : ocnt + 1);
    end
  end

  chk_one_read: assert property (pend |-> !flash_rd)
    else $error("flash read issued while one outstanding");
  chk_addr_hold: assert property (
    pend && !flash_rvalid |=> $stable(flash_addr))
    else $error("flash address moved before answer");
  chk_out_hold: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_data)
      && $stable(out_sop))
    else $error("output byte dropped while stalled");
  chk_sync_out: assert property (
    out_valid && out_sop |-> out_data == SYNC_BYTE)
    else $error("packet start without sync byte");
  chk_pkt_len: assert property (
    out_valid && out_ready && out_sop && ocnt != 0 |-> ocnt == PKT_LEN)
    else $error("output packet length wrong");
  chk_led_on: assert property (
    in_valid && !in_ready |-> ##[1:4] overflow_led)
    else $error("overflow lamp not lit");
  chk_led_hold: assert property (
    $rose(overflow_led) |-> overflow_led [*8])
    else $error("overflow lamp flicker");
  chk_led_len: assert property (led_cnt <= LIM)
    else $error("overflow lamp lit too long");
  chk_led_min: assert property (
    $fell(overflow_led) |-> $past(led_cnt) >= LOW)
    else $error("overflow lamp too short");
endmodule : engine_properties

bind table_insertion_engine engine_properties #(
  .ADDR_W(ADDR_W),
  .MS_CNT(MS_CNT)
) chk_u (
  .sys_clk     (sys_clk),
  .arst_n      (arst_n),
  .in_valid    (in_valid),
  .in_ready    (in_ready),
  .out_data    (out_data),
  .out_sop     (out_sop),
  .out_valid   (out_valid),
  .out_ready   (out_ready),
  .flash_addr  (flash_addr),
  .flash_rd    (flash_rd),
  .flash_rvalid(flash_rvalid),
  .overflow_led(overflow_led)
);

// file: verif/flash_store.sv
// flash table store model answering the engine's reads
module flash_store #(
  parameter int unsigned ADDR_W = 16
) (
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  input  wire logic [ADDR_W-1:0] flash_addr,
  input  wire logic              flash_rd,
  input  wire logic [1:0]        lat,
  output logic [7:0]             flash_rdata,
  output logic                   flash_rvalid
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]        mem [0:2047];
  logic [1:0]        cnt;
  logic              busy;
  logic [ADDR_W-1:0] addr_q;

  // latch address, answer after lat extra cycles
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy         <= 1'b0;
      cnt          <= 2'h0;
      addr_q       <= '0;
      flash_rvalid <= 1'b0;
      flash_rdata  <= 8'h00;
    end else begin
      flash_rvalid <= 1'b0;
      flash_rdata  <= ~flash_rdata;  // stale data never lingers
      if (flash_rd) begin
        busy   <= 1'b1;
        addr_q <= flash_addr;
        cnt    <= lat;
      end else if (busy && cnt != 2'h0) begin
        cnt <= cnt - 2'h1;
      end else if (busy) begin
        busy         <= 1'b0;
        flash_rvalid <= 1'b1;
        flash_rdata  <= mem[addr_q[10:0]];
      end
    end
  end
endmodule : flash_store

// file: verif/tb_top.sv
// self-checking bench for the table insertion engine
module tb_top import table_insert_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk, arst_n, in_sop, in_valid, in_ready, out_sop;
  logic        out_valid, out_ready, flash_rd, flash_rvalid, overflow_led;
  logic [7:0]  in_data, out_data, flash_rdata, ob [0:187];
  logic [15:0] flash_addr;
  logic [3:0]  ccs [0:511];
  logic [1:0]  lat;
  int          fails, n_tests, oi, pat_n, pmt_n, nit_n;
  bit          armed;
  logic [12:0] s_pid [0:6] = '{13'h0, 13'h100, 13'h300, PID_SDT,
                               PID_NIT, 13'h400, 13'h0};
  int          s_cnt [0:6] = '{1, 1, 0, 1, 1, 2, 0};
  int          s_tim [0:6] = '{0, 0, 0, 1, 0, 0, 255};

  // short millisecond keeps lamp and pacing inside the cycle budget
  table_insertion_engine #(.MS_CNT(2)) dut_u (
    .sys_clk(sys_clk), .arst_n(arst_n), .in_data(in_data),
    .in_sop(in_sop), .in_valid(in_valid), .in_ready(in_ready),
    .out_data(out_data), .out_sop(out_sop), .out_valid(out_valid),
    .out_ready(out_ready), .flash_addr(flash_addr), .flash_rd(flash_rd),
    .flash_rdata(flash_rdata), .flash_rvalid(flash_rvalid),
    .overflow_led(overflow_led));
  flash_store flash_u (
    .sys_clk(sys_clk), .arst_n(arst_n), .flash_addr(flash_addr),
    .flash_rd(flash_rd), .lat(lat), .flash_rdata(flash_rdata),
    .flash_rvalid(flash_rvalid));

  always #12.5 sys_clk = ~sys_clk;

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [12:0] e,
                     input logic [12:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one byte offered at a falling edge, held back while fifo is full
  task automatic put_byte(input logic [7:0] d, input logic s);
    int t;
    t = 0;
    @(negedge sys_clk);
    while (in_ready !== 1'b1 && t < 1000) begin
      in_valid = 1'b0;
      t++;
      @(negedge sys_clk);
    end
    if (t == 1000) begin
      fails++;
      conclude();
    end
    in_valid = 1'b1;
    in_data  = d;
    in_sop   = s;
  endtask : put_byte

  task automatic send_pkt(input logic [12:0] pid);
    logic [7:0] d;
    for (int i = 0; i < PKT_LEN; i++) begin
      case (i)
        0: d = SYNC_BYTE;
        1: d = {3'h0, pid[12:8]};
        2: d = pid[7:0];
        3: d = 8'h10;
        default: d = 8'h5a;
      endcase
      put_byte(d, i == 0);
    end
  endtask : send_pkt

  // erase then load while held in reset, restart afterwards
  task automatic do_reset(input bit tables);
    int b;
    @(negedge sys_clk);
    arst_n   = 1'b0;
    in_valid = 1'b0;
    oi       = 200;
    for (int a = 0; a < 2048; a++) flash_u.mem[a] = 8'hff;
    for (int s = 0; s < 7 && tables; s++) begin
      b = s * SLOT_LEN;
      for (int k = 0; k < PKT_LEN; k++)
        flash_u.mem[b+k] = s_pid[s][7:0] ^ 8'ha5;
      flash_u.mem[b]   = (s == 0) ? SYNC_BYTE : 8'h00;
      flash_u.mem[b+1] = {3'h0, s_pid[s][12:8]};
      flash_u.mem[b+2] = s_pid[s][7:0];
      flash_u.mem[b+3] = (s == 5) ? 8'h15 : 8'h10;
      flash_u.mem[b+IDX_COUNT]  = 8'(s_cnt[s]);
      flash_u.mem[b+IDX_TIMING] = 8'(s_tim[s]);
      flash_u.mem[b+IDX_CLASS]  = (s == 5) ? 8'h01 : 8'h00;
    end
    repeat (2) @(negedge sys_clk);
    arst_n = 1'b1;
  endtask : do_reset

  // judge one complete output packet
  task automatic check_pkt();
    logic [12:0] pid;
    pid = {ob[1][4:0], ob[2]};
    chk("sync", SYNC_BYTE, ob[0]);
    if (pid == NULL_PID || pid == 13'h0200) begin
      chk("pass_body", 8'h5a, ob[187]);
      chk("pass_cc", 8'h10, ob[3]);
    end else if (!armed) chk("pid", NULL_PID, pid);
    else begin
      case (pid)
        13'h0000: pat_n++;
        13'h0100: begin
          pmt_n++;
          chk("pmt_rhythm", 13'(pat_n), 13'(pmt_n));
        end
        PID_SDT: chk("sdt_phase", 1, 13'(pat_n % SDT_EVERY));
        PID_NIT: begin
          nit_n++;
          chk("nit_phase", 1, 13'(pat_n % NIT_EVERY));
        end
        13'h0400: chk("user_phase", 1, 13'(pat_n % NIT_EVERY));
        default: chk("pid", 0, pid);
      endcase
      if (pid == 13'h0400) chk("user_cc", 8'h15, ob[3]);
      else begin
        chk("cc", {4'h1, ccs[pid[8:0]]}, ob[3]);
        ccs[pid[8:0]]++;
      end
      chk("body", pid[7:0] ^ 8'ha5, ob[187]);
    end
  endtask : check_pkt

  // gather accepted output bytes into packets
  always @(posedge sys_clk) begin
    if (arst_n && out_valid === 1'b1 && out_ready) begin
      if (out_sop) oi = 0;
      if (oi < PKT_LEN) ob[oi] = out_data;
      if (oi < 1000) oi++;
      if (oi == PKT_LEN) check_pkt();
    end
  end

  task automatic t_pass();
    armed = 0;
    for (int p = 0; p < 6; p++) send_pkt(p[0] ? 13'h0200 : NULL_PID);
    $display("t_pass done");
  endtask : t_pass

  // fill the fifo against a stalled multiplexer, then drain it
  task automatic t_overflow();
    int t;
    @(negedge sys_clk);
    out_ready = 1'b0;
    in_valid  = 1'b1;
    in_sop    = 1'b0;
    in_data   = 8'h5a;
    repeat (30) @(negedge sys_clk);
    chk("full", 0, in_ready);
    chk("led_on", 1, overflow_led);
    in_valid  = 1'b0;
    out_ready = 1'b1;
    repeat (1800) @(negedge sys_clk);
    chk("drained", 1, in_ready);
    chk("led_hold", 1, overflow_led);
    t = 0;
    while (overflow_led && t < 3000) begin
      t++;
      @(negedge sys_clk);
    end
    chk("led_off", 0, overflow_led);
    $display("t_overflow done");
  endtask : t_overflow

  // stored tables replace nulls in a partly loaded stream
  task automatic t_insert();
    lat = 2'h0;
    do_reset(1);
    armed = 1;
    pat_n = 0;
    pmt_n = 0;
    nit_n = 0;
    foreach (ccs[i]) ccs[i] = 4'h0;
    // run until the second nit cycle, bounded by packet count
    for (int p = 0; p < 500 && nit_n < 2; p++)
      send_pkt(p[2:0] == 3'h7 ? 13'h0200 : NULL_PID);
    chk("cycles", 1, 13'(pat_n >= 33 && nit_n >= 2));
    $display("t_insert done");
  endtask : t_insert

  initial begin
    sys_clk   = 1'b0;
    arst_n    = 1'b0;
    in_valid  = 1'b0;
    in_sop    = 1'b0;
    in_data   = 8'h00;
    out_ready = 1'b1;
    lat       = 2'h3;
    do_reset(0);
    t_pass();
    t_overflow();
    t_insert();
    conclude();
  end
endmodule : tb_top
